// [srs_pkg.sv]
// shared types and constants of the serial receiver status block
`default_nettype none
package srs_pkg;

   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int SRS_DATA_W = 9;
   localparam int SRS_FIFO_DEPTH = 8;
   localparam logic [1:0] SRS_BUF_FULL = 2'h2;

   // ------------------------------------------------------------
   // character size codes
   // ------------------------------------------------------------
   localparam logic [2:0] SRS_CSZ_5 = 3'h0;
   localparam logic [2:0] SRS_CSZ_6 = 3'h1;
   localparam logic [2:0] SRS_CSZ_7 = 3'h2;
   localparam logic [2:0] SRS_CSZ_8 = 3'h3;
   localparam logic [2:0] SRS_CSZ_9 = 3'h7;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [SRS_DATA_W-1:0] data;
      logic stop;
      logic par;
   } srs_frame_t;

   localparam int SRS_FRAME_W = $bits(srs_frame_t);

   typedef struct packed {
      logic [SRS_DATA_W-1:0] data;
      logic fe;
      logic overrun_flag;
      logic pe;
   } srs_entry_t;

   typedef struct packed {
      srs_entry_t [1:0] buff;
      logic wp;
      logic rp;
      logic [1:0] cnt;
      srs_frame_t sh;
      logic sh_full;
      logic ovr_pend;
      logic rxc;
      logic irq;
      logic fe;
      logic overrun_flag;
      logic pe;
      logic b8;
      logic [7:0] dat;
   } srs_state_t;

   localparam srs_state_t SRS_STATE_RST = '0;

endpackage
`default_nettype wire

// [srs_fifo.sv]
// parameterised flip-flop fifo with valid/ready on both sides and flush
`default_nettype none
module srs_fifo
   import srs_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [AW:0] FULLC = (AW + 1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic room;
      logic empty;
   } srs_fifo_st_t;

   srs_fifo_st_t s_r;
   srs_fifo_st_t s_nxt;
   logic push;
   logic pop;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      push = in_valid_i && s_r.room;
      pop = out_ready_i && !s_r.empty;
      if (flush_i) begin
         s_nxt.wp = '0;
         s_nxt.rp = '0;
         s_nxt.cnt = '0;
         push = 1'b0;
         pop = 1'b0;
      end else begin
         if (push) begin
            s_nxt.mem[s_r.wp] = in_data_i;
            s_nxt.wp = (s_r.wp == LAST) ? '0 : s_r.wp + 1'b1;
         end
         if (pop) begin
            s_nxt.rp = (s_r.rp == LAST) ? '0 : s_r.rp + 1'b1;
         end
         if (push && !pop) begin
            s_nxt.cnt = s_r.cnt + 1'b1;
         end else if (pop && !push) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
         end
      end
      // flags registered so the ready seen by the source is a flop
      s_nxt.room = (s_nxt.cnt != FULLC);
      s_nxt.empty = (s_nxt.cnt == '0);
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_r <= '{default: '0, room: 1'b1, empty: 1'b1};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign in_ready_o = s_r.room;
   assign out_valid_o = !s_r.empty;
   assign out_data_o = s_r.mem[s_r.rp];

endmodule
`default_nettype wire

// [srs_rx_status.sv]
// receive buffer, status flags, parity check and interrupt request of the serial receiver
// Functional notes
// - receive-complete flag high while any unread frame sits in the buffer.
// - clearing receiver enable empties the buffer; receive-complete then reads zero.
// - interrupt request held while flag, its enable and global enable are set.
// - each entry stores frame, overrun and parity errors; oldest entry shown.
// - software has no write path into the three error flags.
// - error flags never raise an interrupt request.
// - frame error is one when first stop bit was zero.
// - only the first stop bit is checked, whatever stop count.
// - overrun when buffer full, shift stage full and new start seen.
// - overrun flag marks frames lost before the frame now readable.
// - pending overrun clears when a frame moves into the buffer.
// - parity error stored as zero for frames moved in while parity checking is off.
// - checker active only with parity enable; odd select picks the sense.
// - parity of data against parity bit, result stored with frame.
// - ninth data bit buffered per frame, read before the low byte.
// - parity error stays valid for oldest frame until it is read.
`default_nettype none
module srs_rx_status
   import srs_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic receiver_enable_bit_i,
   input wire logic rx_complete_irq_enable_i,
   input wire logic global_irq_enable_i,
   input wire logic parity_enable_bit_i,
   input wire logic parity_odd_select_i,
   input wire logic [2:0] char_size_field_i,
   input wire logic start_detect_i,
   input wire logic frame_valid_i,
   input wire srs_frame_t frame_i,
   output logic frame_ready_o,
   input wire logic data_read_i,
   output logic rx_complete_o,
   output logic irq_o,
   output logic frame_error_flag_o,
   output logic overrun_flag_o,
   output logic parity_error_flag_o,
   output logic rx_ninth_bit_o,
   output logic [7:0] rx_data_o
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [SRS_DATA_W-1:0] mask_data(input logic [SRS_DATA_W-1:0] d,
                                                       input logic [2:0] csz);
      logic [SRS_DATA_W-1:0] m;
      m = '0;
      case (csz)
         SRS_CSZ_5: m = 9'h01F;
         SRS_CSZ_6: m = 9'h03F;
         SRS_CSZ_7: m = 9'h07F;
         SRS_CSZ_8: m = 9'h0FF;
         SRS_CSZ_9: m = 9'h1FF;
         default: m = 9'h0FF;
      endcase
      return d & m;
   endfunction

   srs_state_t s_r;
   srs_state_t s_nxt;
   srs_entry_t head;
   srs_frame_t fifo_data;
   logic fifo_valid;
   logic fifo_pop_rdy;
   logic mv;
   logic rd;
   logic par_err_c;
   logic [SRS_DATA_W-1:0] sh_data_c;

   // ------------------------------------------------------------
   // frame fifo in front of the shift stage
   // ------------------------------------------------------------
   srs_fifo #(
      .WIDTH(SRS_FRAME_W),
      .DEPTH(SRS_FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .flush_i(!receiver_enable_bit_i),
      .in_valid_i(frame_valid_i),
      .in_data_i(frame_i),
      .in_ready_o(frame_ready_o),
      .out_valid_o(fifo_valid),
      .out_data_o(fifo_data),
      .out_ready_i(fifo_pop_rdy)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      head = '0;
      mv = 1'b0;
      rd = 1'b0;
      fifo_pop_rdy = 1'b0;
      sh_data_c = mask_data(s_r.sh.data, char_size_field_i);
      // even check wants an even count of ones over data plus parity bit
      par_err_c = parity_enable_bit_i
                  & ((^sh_data_c) ^ s_r.sh.par ^ parity_odd_select_i);
      if (!receiver_enable_bit_i) begin
         // disable is immediate: buffered and in-flight frames are lost
         s_nxt.cnt = '0;
         s_nxt.wp = 1'b0;
         s_nxt.rp = 1'b0;
         s_nxt.sh_full = 1'b0;
         s_nxt.ovr_pend = 1'b0;
      end else begin
         rd = data_read_i && (s_r.cnt != 2'h0);
         mv = s_r.sh_full && (s_r.cnt != SRS_BUF_FULL);
         if (start_detect_i && s_r.sh_full && (s_r.cnt == SRS_BUF_FULL)) begin
            s_nxt.ovr_pend = 1'b1;
         end
         if (mv) begin
            s_nxt.buff[s_r.wp].data = sh_data_c;
            s_nxt.buff[s_r.wp].fe = ~s_r.sh.stop;
            s_nxt.buff[s_r.wp].overrun_flag = s_r.ovr_pend;
            s_nxt.buff[s_r.wp].pe = par_err_c;
            s_nxt.wp = ~s_r.wp;
            s_nxt.ovr_pend = 1'b0;
         end
         if (rd) begin
            s_nxt.rp = ~s_r.rp;
         end
         if (mv && !rd) begin
            s_nxt.cnt = s_r.cnt + 2'h1;
         end else if (rd && !mv) begin
            s_nxt.cnt = s_r.cnt - 2'h1;
         end
         fifo_pop_rdy = !s_r.sh_full || mv;
         if (fifo_valid && fifo_pop_rdy) begin
            s_nxt.sh = fifo_data;
            s_nxt.sh_full = 1'b1;
         end else if (mv) begin
            s_nxt.sh_full = 1'b0;
         end
      end
      // outputs are taken from the next state so they carry no extra lag
      s_nxt.rxc = (s_nxt.cnt != 2'h0);
      s_nxt.irq = s_nxt.rxc && rx_complete_irq_enable_i && global_irq_enable_i;
      if (s_nxt.rxc) begin
         head = s_nxt.buff[s_nxt.rp];
      end
      // status has no write path, so error flags only change with the buffer
      s_nxt.fe = head.fe;
      s_nxt.overrun_flag = head.overrun_flag;
      s_nxt.pe = head.pe;
      s_nxt.b8 = head.data[8];
      s_nxt.dat = head.data[7:0];
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_r <= SRS_STATE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rx_complete_o = s_r.rxc;
   assign irq_o = s_r.irq;
   assign frame_error_flag_o = s_r.fe;
   assign overrun_flag_o = s_r.overrun_flag;
   assign parity_error_flag_o = s_r.pe;
   assign rx_ninth_bit_o = s_r.b8;
   assign rx_data_o = s_r.dat;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);

   a_rxc_tracks_buffer: assert property (rx_complete_o == (s_r.cnt != 2'h0))
      else $error("receive-complete does not match buffer fill");

   a_move_sets_rxc: assert property (mv |=> rx_complete_o)
      else $error("frame moved but receive-complete low");

   a_disable_flushes: assert property (
      !receiver_enable_bit_i |=> !rx_complete_o && !s_r.sh_full && !fifo_valid && !s_r.ovr_pend)
      else $error("receiver disable did not flush the buffer");

   a_irq_level: assert property (
      irq_o == (rx_complete_o && $past(rx_complete_irq_enable_i) && $past(global_irq_enable_i)))
      else $error("interrupt request not held with flag and enables");

   a_read_drops_flag: assert property (
      rd && !mv && s_r.cnt == 2'h1 |=> !rx_complete_o && !irq_o)
      else $error("last read did not drop receive-complete");

   a_no_error_irq: assert property (!rx_complete_o |-> !irq_o)
      else $error("interrupt raised with no unread frame");

   a_empty_flags_low: assert property (
      !rx_complete_o |-> !frame_error_flag_o && !overrun_flag_o && !parity_error_flag_o)
      else $error("error flags shown with an empty buffer");

   a_status_oldest: assert property (
      rx_complete_o |-> frame_error_flag_o == s_r.buff[s_r.rp].fe
      && overrun_flag_o == s_r.buff[s_r.rp].overrun_flag && parity_error_flag_o == s_r.buff[s_r.rp].pe)
      else $error("status does not show oldest entry");

   // a move only fills the free slot, so the shown entry must hold still
   a_flags_stand: assert property (
      rx_complete_o && !rd && receiver_enable_bit_i |=> $stable(frame_error_flag_o)
      && $stable(overrun_flag_o) && $stable(parity_error_flag_o) && $stable(rx_data_o))
      else $error("buffered status changed without a read");

   a_frame_error_stop: assert property (
      mv |=> s_r.buff[$past(s_r.wp)].fe == $past(~s_r.sh.stop))
      else $error("frame error does not follow first stop bit");

   a_overrun_set: assert property (
      receiver_enable_bit_i && start_detect_i && s_r.sh_full && s_r.cnt == SRS_BUF_FULL
      |=> s_r.ovr_pend)
      else $error("overrun not flagged");

   a_overrun_cause: assert property (
      $rose(s_r.ovr_pend) |-> $past(start_detect_i) && $past(s_r.sh_full)
      && $past(s_r.cnt) == SRS_BUF_FULL)
      else $error("overrun raised without a full buffer and a start bit");

   a_overrun_carried: assert property (
      mv |=> s_r.buff[$past(s_r.wp)].overrun_flag == $past(s_r.ovr_pend) && !s_r.ovr_pend)
      else $error("overrun not carried by next frame or not cleared");

   a_overrun_holds: assert property (
      s_r.ovr_pend && !mv && receiver_enable_bit_i |=> s_r.ovr_pend)
      else $error("pending overrun lost before a frame moved");

   a_parity_off: assert property (
      mv && !parity_enable_bit_i |=> !s_r.buff[$past(s_r.wp)].pe)
      else $error("parity error set while checking disabled");

   a_parity_stored: assert property (
      mv |=> s_r.buff[$past(s_r.wp)].pe == $past(par_err_c))
      else $error("parity result not stored with frame");

   // sense judged by counting ones, independent of the xor tree above
   a_parity_sense: assert property (
      mv && parity_enable_bit_i |=> s_r.buff[$past(s_r.wp)].pe
      == ((($past($countones({sh_data_c, s_r.sh.par})) % 2) != 0) != $past(parity_odd_select_i)))
      else $error("parity check sense does not follow odd select");

   a_ninth_bit_kept: assert property (
      mv && char_size_field_i == SRS_CSZ_9
      |=> s_r.buff[$past(s_r.wp)].data == $past(s_r.sh.data))
      else $error("ninth data bit not kept with the frame");

   a_read_advances: assert property (rd && !mv |=> s_r.cnt == $past(s_r.cnt) - 2'h1)
      else $error("data read did not advance buffer");

   c_buffer_full: cover property (s_r.cnt == SRS_BUF_FULL);
   c_overrun_seen: cover property (overrun_flag_o && rx_complete_o);
   c_parity_error: cover property (parity_error_flag_o ##1 rd);
   c_irq_then_read: cover property (irq_o ##[1:20] !rx_complete_o);

endmodule
`default_nettype wire

// [srs_tx_model.sv]
// remote serial transmitter model driving frames into the receive status block
`default_nettype none
module srs_tx_model
   import srs_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic frame_ready_i,
   output logic frame_valid_o,
   output srs_frame_t frame_o,
   output logic start_detect_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // ------------------------------------------------------------
   // idle line
   // ------------------------------------------------------------
   initial begin
      frame_valid_o = 1'h0;
      frame_o = '0;
      start_detect_o = 1'h0;
   end

   // ------------------------------------------------------------
   // frame offer, held until taken; caller enters just after an edge
   // ------------------------------------------------------------
   // only one stop bit is carried, later stop bits never reach the block
   task automatic send(input logic [8:0] d, input logic stp, input logic par, output bit ok);
      ok = 1'h0;
      frame_valid_o <= 1'h1;
      frame_o <= '{data: d, stop: stp, par: par};
      for (int n = 0; n < 40 && !ok; n++) begin
         @(negedge sys_clk_i);
         ok = frame_ready_i;
      end
      @(posedge sys_clk_i);
   endtask

   // released data is inverted so a stale copy is never mistaken for a frame
   task automatic release_line();
      frame_valid_o <= 1'h0;
      frame_o <= ~frame_o;
      @(posedge sys_clk_i);
   endtask

   task automatic start_pulse();
      start_detect_o <= 1'h1;
      @(posedge sys_clk_i);
      start_detect_o <= 1'h0;
      @(posedge sys_clk_i);
   endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking testbench of the serial receiver status block
`default_nettype none
module tb_top
   import srs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic sys_clk_i, arst_n_i, en, ie, ge, pen, podd, data_read_i;
   logic [2:0] csz;
   logic valid, start, ready, rxc, irq, fe, overrun_flag, pe, b8;
   logic [7:0] dat;
   srs_frame_t frame;
   int errors, samples_checked;
   localparam logic [3:0] CASES [6] = '{4'h9, 4'hB, 4'hD, 4'hF, 4'h3, 4'h8};

   srs_tx_model i_srs_tx_model (.sys_clk_i(sys_clk_i), .frame_ready_i(ready),
      .frame_valid_o(valid), .frame_o(frame), .start_detect_o(start));

   srs_rx_status i_srs_rx_status (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
      .receiver_enable_bit_i(en), .rx_complete_irq_enable_i(ie), .global_irq_enable_i(ge),
      .parity_enable_bit_i(pen), .parity_odd_select_i(podd), .char_size_field_i(csz),
      .start_detect_i(start), .frame_valid_i(valid), .frame_i(frame), .frame_ready_o(ready),
      .data_read_i(data_read_i), .rx_complete_o(rxc), .irq_o(irq),
      .frame_error_flag_o(fe), .overrun_flag_o(overrun_flag), .parity_error_flag_o(pe),
      .rx_ninth_bit_o(b8), .rx_data_o(dat));

   initial begin
      sys_clk_i = 1'h0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic close_out();
      $display("counts: errors %0d, checks %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tx(input logic [8:0] d, input logic stp, input logic par);
      bit ok;
      i_srs_tx_model.send(d, stp, par, ok);
      if (!ok) begin
         errors++;
         close_out();
      end
   endtask

   // status and ninth bit are compared before the read pulse moves the buffer
   task automatic rd(input logic [8:0] d, input logic f, input logic o, input logic p);
      bit seen;
      seen = 1'h0;
      for (int n = 0; n < 40 && !seen; n++) begin
         @(negedge sys_clk_i);
         seen = (rxc === 1'h1);
      end
      if (!seen) begin
         errors++;
         close_out();
      end
      chk("irq", {8'h0, ie & ge}, {8'h0, irq});
      chk("flags", {6'h0, f, o, p}, {6'h0, fe, overrun_flag, pe});
      chk("data", d, {b8, dat});
      @(posedge sys_clk_i);
      data_read_i <= 1'h1;
      @(posedge sys_clk_i);
      data_read_i <= 1'h0;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   // no status write port exists, so error bits are never written
   initial begin
      logic [3:0] c;
      arst_n_i = 1'h0;
      en = 1'h1;
      ie = 1'h1;
      ge = 1'h1;
      pen = 1'h0;
      podd = 1'h0;
      csz = SRS_CSZ_8;
      data_read_i = 1'h0;
      errors = 0;
      samples_checked = 0;
      repeat (20) @(posedge sys_clk_i);
      arst_n_i <= 1'h1;
      @(negedge sys_clk_i);
      chk("ready", 9'h001, {8'h0, ready});
      chk("rx complete", 9'h000, {8'h0, rxc});
      $display("test reset done");
      // {parity on, odd, parity bit, stop bit}; data 03 has an even count of ones
      for (int i = 0; i < 6; i++) begin
         c = CASES[i];
         @(posedge sys_clk_i);
         pen <= c[3];
         podd <= c[2];
         ie <= ~i[0];
         ge <= (i != 2);
         tx(9'h003, c[0], c[1]);
         i_srs_tx_model.release_line();
         rd(9'h003, ~c[0], 1'h0, c[3] & (c[1] ^ c[2]));
      end
      @(negedge sys_clk_i);
      chk("rx complete", 9'h000, {8'h0, rxc});
      chk("irq", 9'h000, {8'h0, irq});
      $display("test flags done");
      @(posedge sys_clk_i);
      csz <= SRS_CSZ_9;
      pen <= 1'h0;
      ie <= 1'h1;
      tx(9'h1A5, 1'h1, 1'h0);
      i_srs_tx_model.release_line();
      rd(9'h1A5, 1'h0, 1'h0, 1'h0);
      // five to seven bit characters: upper bits masked, parity over kept bits only
      for (int k = 0; k < 3; k++) begin
         @(posedge sys_clk_i);
         csz <= SRS_CSZ_5 + 3'(k);
         pen <= 1'h1;
         podd <= 1'h0;
         tx(9'h0FF, 1'h1, 1'h0);
         i_srs_tx_model.release_line();
         rd(9'h0FF >> (3 - k), 1'h0, 1'h0, ~k[0]);
      end
      @(posedge sys_clk_i);
      csz <= SRS_CSZ_8;
      pen <= 1'h0;
      $display("test ninth bit done");
      // two buffered, one in the shift stage, eight in the fifo
      for (int i = 0; i < 11; i++)
         tx(9'(i), 1'h1, 1'h0);
      i_srs_tx_model.release_line();
      repeat (4) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk("ready when full", 9'h000, {8'h0, ready});
      @(posedge sys_clk_i);
      i_srs_tx_model.start_pulse();
      for (int i = 0; i < 11; i++)
         rd(9'(i), 1'h0, i == 2, 1'h0);
      repeat (3) @(negedge sys_clk_i);
      chk("rx complete", 9'h000, {8'h0, rxc});
      $display("test fill and overrun done");
      @(posedge sys_clk_i);
      // two buffered, one in the shift stage, one in the fifo when enable drops
      tx(9'h055, 1'h1, 1'h0);
      tx(9'h0AA, 1'h1, 1'h0);
      tx(9'h033, 1'h1, 1'h0);
      tx(9'h0CC, 1'h1, 1'h0);
      i_srs_tx_model.release_line();
      repeat (4) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk("rx complete", 9'h001, {8'h0, rxc});
      @(posedge sys_clk_i);
      en <= 1'h0;
      repeat (3) @(negedge sys_clk_i);
      chk("rx complete", 9'h000, {8'h0, rxc});
      chk("irq", 9'h000, {8'h0, irq});
      @(posedge sys_clk_i);
      en <= 1'h1;
      repeat (4) @(negedge sys_clk_i);
      chk("rx complete", 9'h000, {8'h0, rxc});
      $display("test disable done");
      close_out();
   end
endmodule
`default_nettype wire
